//--- hdl/aiwm_top.sv
/*
  Analog input word mux, 16-point mode. Keeps the latest result of
  each of four channels and on every controller scan presents one
  enabled channel, or all zeros when none is enabled, on a 16-bit input word:
    bits 11..0 magnitude, 13..12 channel code, 14 broken loop,
    15 sign.
  Assumes conversion results arrive as one-cycle strobes with their
  channel number, and scan_tick pulses once per controller scan, both
  synchronous to pclk. Registers are reached over APB.
*/
`timescale 1ns/1ps
`include "aiwm_consts.svh"
module aiwm_top
  import aiwm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        conv_valid,
  input  wire logic [1:0]  conv_ch,
  input  wire logic [12:0] conv_code,
  input  wire logic        conv_loop_low,
  input  wire logic        scan_tick,
  output logic      [15:0] in_word
);

  aiwm_reg_if   rif ();

  aiwm_state_e  st_r;
  aiwm_state_e  st_nxt;
  aiwm_ch_t     ch_r;
  aiwm_ch_t     ch_nxt;
  logic [15:0]  word_nxt;
  logic [1:0]   evt_r;
  logic [3:0]   en_q;

  aiwm_mag_t    slot_mag_r [4];
  logic [3:0]   slot_neg_r;
  logic [3:0]   slot_brk_r;
  aiwm_sample_s smp;

  // Register slave with sticky events and the interrupt line
  aiwm_apb u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .irq     (irq),
    .rif     (rif)
  );

  // One shared formatter; only one conversion lands per cycle
  aiwm_fmt u_fmt (
    .code     (conv_code),
    .bipolar  (rif.bip[conv_ch]),
    .ma_range (rif.ma[conv_ch]),
    .loop_low (conv_loop_low),
    .smp      (smp)
  );

  // First enabled channel at or after base, in channel order.
  // With one channel enabled it always returns that channel.
  function automatic aiwm_ch_t next_ch(input aiwm_ch_t base,
                                       input logic [3:0] en);
    aiwm_ch_t cand;
    next_ch = base;
    for (int k = 3; k >= 0; k--) begin
      cand = base + 2'(k);
      if (en[cand]) begin
        next_ch = cand;
      end
    end
  endfunction

  // Latest result of every channel; the fault bit follows each new
  // conversion, so it drops as soon as the loop current recovers
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_slot
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          slot_mag_r[gi] <= 12'h000;
          slot_neg_r[gi] <= 1'b0;
          slot_brk_r[gi] <= 1'b0;
        end else if (conv_valid && conv_ch == 2'(gi)) begin
          slot_mag_r[gi] <= smp.mag;
          slot_neg_r[gi] <= smp.neg;
          slot_brk_r[gi] <= smp.brk;
        end
      end
    end
  endgenerate

  // Scan sequencer: idle while nothing is enabled, else rotate.
  // From idle the search starts at the current code, otherwise at
  // the code after it, so a lone channel repeats every scan.
  always_comb begin
    st_nxt = st_r;
    ch_nxt = ch_r;
    case (st_r)
      AIWM_IDLE: begin
        if (scan_tick && |rif.en) begin
          st_nxt = AIWM_RUN;
          ch_nxt = next_ch(ch_r, rif.en);
        end
      end
      AIWM_RUN: begin
        if (scan_tick) begin
          if (|rif.en) begin
            ch_nxt = next_ch(ch_r + 2'h1, rif.en);
          end else begin
            st_nxt = AIWM_IDLE;
            ch_nxt = 2'h0;
          end
        end
      end
      default: begin
        st_nxt = AIWM_IDLE;
        ch_nxt = 2'h0;
      end
    endcase
  end

  // Word assembly for the channel chosen for the coming scan
  always_comb begin
    word_nxt = 16'h0000;
    if (st_nxt == AIWM_RUN) begin
      word_nxt[`AIWM_MAG_MSB:0] = slot_mag_r[ch_nxt];
      word_nxt[`AIWM_CH_MSB:`AIWM_CH_LSB] = ch_nxt;
      word_nxt[`AIWM_BRK_BIT] = slot_brk_r[ch_nxt];
      word_nxt[`AIWM_SIGN_BIT] = slot_neg_r[ch_nxt];
    end
  end

  // State and channel code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= AIWM_IDLE;
      ch_r <= 2'h0;
    end else begin
      st_r <= st_nxt;
      ch_r <= ch_nxt;
    end
  end

  // The word changes only on a scan boundary, so the controller
  // never reads data of one channel under the code of another
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_word <= 16'h0000;
    end else if (scan_tick) begin
      in_word <= word_nxt;
    end
  end

  // Events: a word presented, and a loop that just broke
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_r <= 2'h0;
    end else begin
      evt_r[`AIWM_EVT_SCAN] <= scan_tick & (st_nxt == AIWM_RUN);
      evt_r[`AIWM_EVT_BRK]  <= conv_valid & smp.brk
                               & ~slot_brk_r[conv_ch];
    end
  end

  // Enable mask seen at the last edge, read only by checks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 4'h0;
    end else begin
      en_q <= rif.en;
    end
  end

  assign rif.evt  = evt_r;
  assign rif.word = in_word;
  assign rif.ch   = ch_r;
  assign rif.run  = (st_r == AIWM_RUN);

  // Checks

  a_code_matches_ch: assert property (
    @(posedge pclk) disable iff (!presetn)
    scan_tick |=> in_word[13:12] == ch_r)
    else $error("channel code bits differ from presented channel");

  a_single_ch_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    scan_tick && st_r == AIWM_RUN && $onehot(rif.en)
      && rif.en[ch_r] |=> ch_r == $past(ch_r))
    else $error("single enabled channel was rotated away");

  a_only_enabled_ch: assert property (
    @(posedge pclk) disable iff (!presetn)
    scan_tick && |rif.en |=> en_q[ch_r] && st_r == AIWM_RUN)
    else $error("disabled channel presented");

  a_data_low_bits: assert property (
    @(posedge pclk) disable iff (!presetn)
    scan_tick && |rif.en && !conv_valid
      |=> in_word[11:0] == slot_mag_r[ch_r])
    else $error("presented data is not the channel result");

  a_sign_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    scan_tick && |rif.en && !conv_valid
      |=> in_word[15] == slot_neg_r[ch_r])
    else $error("sign bit differs from presented channel");

  a_word_stable: assert property (
    @(posedge pclk) disable iff (!presetn)
    !scan_tick |=> $stable(in_word))
    else $error("input word changed between scans");

  a_unipolar_pos: assert property (
    @(posedge pclk) disable iff (!presetn)
    conv_valid && !rif.bip[conv_ch]
      |=> !slot_neg_r[$past(conv_ch)])
    else $error("unipolar result marked negative");

  a_bipolar_sign: assert property (
    @(posedge pclk) disable iff (!presetn)
    conv_valid && rif.bip[conv_ch] && conv_code[12]
      |=> slot_neg_r[$past(conv_ch)] && slot_mag_r[$past(conv_ch)]
          != 12'h000)
    else $error("negative bipolar result lost its sign");

  a_brk_needs_ma: assert property (
    @(posedge pclk) disable iff (!presetn)
    conv_valid && (!rif.ma[conv_ch] || !conv_loop_low)
      |=> !slot_brk_r[$past(conv_ch)])
    else $error("fault flag set outside 4-20 mA or loop healthy");

  a_brk_self_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    scan_tick && |rif.en && !conv_valid && !slot_brk_r[ch_nxt]
      |=> !in_word[14])
    else $error("fault flag stayed after loop recovered");

  a_idle_word_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    scan_tick && rif.en == 4'h0 |=> in_word == 16'h0000
      && st_r == AIWM_IDLE)
    else $error("word not cleared with no channel enabled");

  a_rotate_next: assert property (
    @(posedge pclk) disable iff (!presetn)
    scan_tick && st_r == AIWM_RUN && $countones(rif.en) > 1
      && rif.en[ch_r] |=> ch_r != $past(ch_r))
    else $error("channel not rotated with several enabled");

  a_scan_event: assert property (
    @(posedge pclk) disable iff (!presetn)
    scan_tick && |rif.en |=> evt_r[`AIWM_EVT_SCAN])
    else $error("presented word raised no event");

  a_idle_no_event: assert property (
    @(posedge pclk) disable iff (!presetn)
    scan_tick && rif.en == 4'h0 |=> !evt_r[`AIWM_EVT_SCAN])
    else $error("event raised with no channel enabled");

  a_lone_ch_code: assert property (
    @(posedge pclk) disable iff (!presetn)
    scan_tick && rif.en == 4'h8 |=> in_word[13:12] == 2'h3)
    else $error("lone fourth channel not presented");

  a_ch2_low_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    scan_tick && st_r == AIWM_RUN && rif.en == 4'hf && ch_r == 2'h0
      |=> in_word[12] && !in_word[13])
    else $error("second channel code is not 01");

  a_uni_neg_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    conv_valid && !rif.bip[conv_ch] && conv_code[12]
      |=> slot_mag_r[$past(conv_ch)] == 12'h000)
    else $error("negative unipolar result not clamped to zero");

  a_bip_full_scale: assert property (
    @(posedge pclk) disable iff (!presetn)
    conv_valid && rif.bip[conv_ch] && conv_code == 13'h1000
      |=> slot_mag_r[$past(conv_ch)] == `AIWM_MAG_MAX)
    else $error("most negative bipolar code not at full scale");

  a_brk_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    conv_valid && rif.ma[conv_ch] && conv_loop_low
      |=> slot_brk_r[$past(conv_ch)])
    else $error("low loop current not flagged");

  a_brk_event: assert property (
    @(posedge pclk) disable iff (!presetn)
    conv_valid && rif.ma[conv_ch] && conv_loop_low
      && !slot_brk_r[conv_ch] |=> evt_r[`AIWM_EVT_BRK])
    else $error("newly broken loop raised no event");

endmodule

//--- hdl/aiwm_consts.svh
/*
  Constants of the analog input word mux: word layout, register map,
  reset values. Definitions only; included by aiwm_top, aiwm_fmt and aiwm_apb.
  Assumes the including file has set its own timescale.
*/
`ifndef AIWM_CONSTS_SVH
`define AIWM_CONSTS_SVH

`define AIWM_MAG_MSB   11
`define AIWM_CH_LSB    12
`define AIWM_CH_MSB    13
`define AIWM_BRK_BIT   14
`define AIWM_SIGN_BIT  15
`define AIWM_MAG_MAX   12'hfff

`define AIWM_OFS_CFG   12'h000
`define AIWM_OFS_STAT  12'h004
`define AIWM_OFS_ISTAT 12'h008
`define AIWM_OFS_IMASK 12'h00c

`define AIWM_CFG_RST   12'h001
`define AIWM_EVT_SCAN  0
`define AIWM_EVT_BRK   1

`endif

//--- hdl/aiwm_pkg.sv
/*
  Types of the analog input word mux.
  Assumes nothing of its surroundings.
*/
package aiwm_pkg;
  typedef logic [1:0]  aiwm_ch_t;
  typedef logic [11:0] aiwm_mag_t;

  typedef enum logic [1:0] {
    AIWM_IDLE = 2'b01,
    AIWM_RUN  = 2'b10
  } aiwm_state_e;

  typedef struct packed {
    logic      neg;
    logic      brk;
    aiwm_mag_t mag;
  } aiwm_sample_s;
endpackage

//--- hdl/aiwm_reg_if.sv
/*
  Carrier between the register slave and the word mux core.
  Assumes both ends run on the same pclk.
*/
`timescale 1ns/1ps
interface aiwm_reg_if;
  logic [3:0]  en;
  logic [3:0]  bip;
  logic [3:0]  ma;
  logic [1:0]  evt;
  logic [15:0] word;
  logic [1:0]  ch;
  logic        run;

  modport regs (output en, bip, ma, input evt, word, ch, run);
  modport core (input en, bip, ma, output evt, word, ch, run);
endinterface

//--- hdl/aiwm_fmt.sv
/*
  Turns one signed conversion code into magnitude, sign and fault.
  Assumes the converter delivers a 13-bit two's complement code.
*/
`timescale 1ns/1ps
`include "aiwm_consts.svh"
module aiwm_fmt
  import aiwm_pkg::*;
(
  input  wire logic [12:0]  code,
  input  wire logic         bipolar,
  input  wire logic         ma_range,
  input  wire logic         loop_low,
  output aiwm_sample_s      smp
);
  logic [12:0] absv;

  // Negative unipolar codes clamp to zero; bipolar -4096 clamps to full scale
  always_comb begin
    absv = code[12] ? 13'(-code) : code;
    smp.neg = 1'b0;
    smp.brk = ma_range & loop_low;
    if (!bipolar) begin
      smp.mag = code[12] ? 12'h000 : code[11:0];
    end else begin
      smp.neg = code[12];
      smp.mag = absv[12] ? `AIWM_MAG_MAX : absv[11:0];
    end
  end
endmodule

//--- hdl/aiwm_apb.sv
/*
  APB slave: configuration, status, sticky interrupt bits and mask.
  Assumes an APB master; answers in the access cycle, no wait states.
*/
`timescale 1ns/1ps
`include "aiwm_consts.svh"
module aiwm_apb
  import aiwm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  aiwm_reg_if.regs         rif
);
  logic [11:0] cfg_r;
  logic [1:0]  istat_r;
  logic [1:0]  imask_r;
  logic [1:0]  clr;
  logic [2:0]  rd_dec;
  logic [2:0]  wr_dec;
  logic        setup;
  logic        wr_acc;

  // Valid flag and register index of an address
  function automatic logic [2:0] dec(input logic [11:0] a);
    if (a == `AIWM_OFS_CFG) dec = 3'h4;
    else if (a == `AIWM_OFS_STAT) dec = 3'h5;
    else if (a == `AIWM_OFS_ISTAT) dec = 3'h6;
    else if (a == `AIWM_OFS_IMASK) dec = 3'h7;
    else dec = 3'h0;
  endfunction

  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite & ~pslverr;
  assign rd_dec = dec(paddr);
  assign wr_dec = dec(paddr);
  assign clr = (wr_acc && wr_dec == 3'h6) ? pwdata[1:0] : 2'h0;

  assign rif.en  = cfg_r[3:0];
  assign rif.bip = cfg_r[7:4];
  assign rif.ma  = cfg_r[11:8];

  // Answer prepared at setup, so every bus output is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~rd_dec[2]; // Stands only alongside pready
      if (setup) begin
        case (rd_dec)
          3'h4:    prdata <= {20'h00000, cfg_r};
          3'h5:    prdata <= {13'h0, rif.run, rif.ch, rif.word};
          3'h6:    prdata <= {30'h0, istat_r};
          3'h7:    prdata <= {30'h0, imask_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration and mask writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r   <= `AIWM_CFG_RST;
      imask_r <= 2'h0;
    end else if (wr_acc) begin
      if (wr_dec == 3'h4) cfg_r <= pwdata[11:0];
      else if (wr_dec == 3'h7) imask_r <= pwdata[1:0];
    end
  end

  // Sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_r <= 2'h0;
      irq     <= 1'b0;
    end else begin
      istat_r <= (istat_r & ~clr) | rif.evt;
      irq     <= |(istat_r & imask_r);
    end
  end
endmodule

//--- sim/aiwm_ctrl_model.sv
/*
  Model of the reading controller: files each scanned word by its
  channel code and splits the shared sign and fault bits per channel.
  Assumes in_word is fresh on the cycle after a scan_tick was taken.
*/
`timescale 1ns/1ps
module aiwm_ctrl_model (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             scan_tick,
  input  wire logic [15:0]      in_word,
  output logic      [3:0][11:0] slot_r,
  output logic      [3:0]       sign_r,
  output logic      [3:0]       brk_r
);
  logic tick_d_r;

  // Read one cycle after the tick, never in the tick's own cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_d_r <= 1'b0;
      slot_r   <= '0;
      sign_r   <= 4'h0;
      brk_r    <= 4'h0;
    end else begin
      tick_d_r <= scan_tick;
      if (tick_d_r) begin
        slot_r[in_word[13:12]] <= in_word[11:0];
        sign_r[in_word[13:12]] <= in_word[15];
        brk_r[in_word[13:12]]  <= in_word[14];
      end
    end
  end
endmodule

//--- sim/analog_input_word_mux_tb_top.sv
/*
  Testbench of the analog input word mux: APB register access,
  conversion strobes and scan ticks, with a controller model reading.
  Assumes the design answers APB with pready and needs no other clock.
*/
`timescale 1ns/1ps
module analog_input_word_mux_tb_top;
  logic              pclk, presetn, psel, penable, pwrite, irq;
  logic              pready, pslverr, err, conv_valid, conv_loop_low;
  logic              scan_tick;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, q;
  logic [1:0]        conv_ch;
  logic [12:0]       conv_code;
  logic [15:0]       in_word;
  logic [3:0][11:0]  m_slot;
  logic [3:0]        m_sign, m_brk;
  int                fail_count, comparisons, cycles;

  aiwm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .conv_valid(conv_valid), .conv_ch(conv_ch), .conv_code(conv_code),
    .conv_loop_low(conv_loop_low), .scan_tick(scan_tick),
    .in_word(in_word));

  aiwm_ctrl_model ctrl (.pclk(pclk), .presetn(presetn),
    .scan_tick(scan_tick), .in_word(in_word), .slot_r(m_slot),
    .sign_r(m_sign), .brk_r(m_brk));

  // 40 MHz clock
  always #12.5 pclk = ~pclk;

  // Hang guard: a run far longer than the tests need is a failure
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic conv(input logic [1:0] c, input logic [12:0] k,
                      input logic lo);
    @(posedge pclk);
    conv_valid    <= 1'b1;
    conv_ch       <= c;
    conv_code     <= k;
    conv_loop_low <= lo;
    @(posedge pclk);
    conv_valid <= 1'b0;
  endtask

  // Word is checked once the taking edge has settled
  task automatic scan(input logic [15:0] exp);
    @(posedge pclk);
    scan_tick <= 1'b1;
    @(posedge pclk);
    scan_tick <= 1'b0;
    @(negedge pclk);
    chk({16'h0, in_word}, {16'h0, exp});
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite, conv_valid} = '0;
    {conv_loop_low, scan_tick, paddr, pwdata, conv_ch, conv_code} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h001);
    rd(12'h00c, 32'h0);
    rd(12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("test reset done");
    conv(2'd0, 13'h0fff, 1'b0);
    scan(16'h0fff);
    conv(2'd0, 13'h1ffb, 1'b1);
    scan(16'h0000);
    $display("test unipolar done");
    apb(1'b1, 12'h00c, 32'h3);
    apb(1'b1, 12'h000, 32'h87f);
    rd(12'h000, 32'h87f);
    conv(2'd0, 13'h0064, 1'b1);
    conv(2'd1, 13'h1000, 1'b0);
    conv(2'd2, 13'h1fff, 1'b0);
    conv(2'd3, 13'h0005, 1'b1);
    scan(16'h9fff);
    scan(16'ha001);
    scan(16'h7005);
    scan(16'h0064);
    scan(16'h9fff);
    chk({12'h0, m_sign, m_brk, m_slot[2]}, 32'h68001);
    chk({8'h0, m_slot[0], m_slot[3]}, 32'h0006_4005);
    chk({20'h0, m_slot[1]}, 32'h0000_0fff);
    rd(12'h004, 32'h0005_9fff);
    rd(12'h008, 32'h3);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h008, 32'h3);
    rd(12'h008, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test rotation done");
    apb(1'b1, 12'h00c, 32'h0);
    scan(16'ha001);
    rd(12'h008, 32'h1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h00c, 32'h1);
    rd(12'h00c, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h008, 32'h1);
    rd(12'h008, 32'h0);
    $display("test interrupt done");
    apb(1'b1, 12'h000, 32'h808);
    conv(2'd3, 13'h0005, 1'b0);
    scan(16'h3005);
    scan(16'h3005);
    apb(1'b1, 12'h000, 32'h0);
    scan(16'h0000);
    $display("test single done");
    print_verdict();
  end
endmodule
